// File: hw/ssm_pkg.sv
// Package of constants and types for the sleep-mode control block
package ssm_pkg;

    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned SLEEP_RECOVERY_TIME_NS = 20;
    // Least time: round up, at least one cycle
    localparam int unsigned RECOVERY_CYC_RAW =
        (SLEEP_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RECOVERY_CYC = (RECOVERY_CYC_RAW < 1) ? 1 : RECOVERY_CYC_RAW;
    localparam int unsigned ENTRY_CYC       = 2;
    localparam int unsigned CNT_W           = 4;
    localparam int unsigned ADDR_W          = 2;
    localparam int unsigned DATA_W          = 18;

    localparam logic [CNT_W-1:0] CNT_ZERO   = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE    = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_ONE  = 2'h1;

    typedef enum logic [3:0] {
        SSM_RUN     = 4'h1,
        SSM_ENTER   = 4'h2,
        SSM_SLEEP   = 4'h4,
        SSM_RECOVER = 4'h8
    } ssm_state_t;

endpackage : ssm_pkg

// File: hw/ssm_sync_if.sv
// Interface carrying the synchronised sleep request
`timescale 1ns/1ns
interface ssm_sync_if;
    logic sleep_req;
    modport src (output sleep_req);
    modport dst (input  sleep_req);
endinterface : ssm_sync_if

// File: hw/ssm_sync.sv
// Two-flop synchroniser for the asynchronous sleep request
`timescale 1ns/1ns
module ssm_sync
    import ssm_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic ce_i,
    input  wire logic async_i,
    ssm_sync_if.src   out
);
    typedef struct packed {
        logic meta;
        logic sync;
    } ssm_sync_st_t;

    ssm_sync_st_t st_r;
    ssm_sync_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (ce_i) begin
            st_nxt.meta = async_i;
            st_nxt.sync = st_r.meta;
        end
    end

    always_ff @(posedge clk_i) begin
        st_r <= st_nxt;
    end

    assign out.sleep_req = st_r.sync;
endmodule : ssm_sync

// File: hw/ssm_top.sv
// Sleep-mode entry, exit and deselect gating of a burst SRAM core
//
// Summary of operation
// - Enter sleep two cycles after request
// - Sleep keeps burst address and read data intact; select, read, write and output enable clear
// - Writes resume only after 20 ns recovery; reads pass during it
// - Asleep: deselected, inputs ignored, outputs high-Z
// - Asynchronous request; asleep while held high
// - No pull-down: an undriven request is not forced low
// - Dummy read advances burst counter
`timescale 1ns/1ns
module ssm_top
    import ssm_pkg::*;
#(
    parameter int unsigned AW = ADDR_W,
    parameter int unsigned DW = DATA_W
)(
    // Clock, reset, enable
    input  wire logic          CLK_I,
    input  wire logic          SRST_I,
    input  wire logic          CE_I,
    // Sleep request pin (no pull-down; undriven is not forced low)
    input  wire logic          SLEEP_REQUEST_I,
    // Core command inputs
    input  wire logic          SELECT_I,
    input  wire logic          READ_I,
    input  wire logic          WRITE_I,
    input  wire logic          LOAD_I,
    input  wire logic          ADVANCE_I,
    input  wire logic [AW-1:0] ADDR_I,
    input  wire logic          OUT_GATE_I,
    input  wire logic [DW-1:0] RDATA_I,
    // Gated outputs
    output logic               SLEEP_O,
    output logic               RECOVERING_O,
    output logic               SELECT_O,
    output logic               READ_O,
    output logic               WRITE_O,
    output logic [AW-1:0]      BURST_ADDR_O,
    output logic [DW-1:0]      DQ_O,
    output logic               DQ_OE_O
);
    ////////////////////////////////////////////////////////////////////////////
    ssm_sync_if sync_bus ();

    // no pull-down: the request pin goes straight into the synchroniser
    ssm_sync u_sync (
        .clk_i   (CLK_I),
        .ce_i    (CE_I),
        .async_i (SLEEP_REQUEST_I),
        .out     (sync_bus.src)
    );

    typedef struct packed {
        ssm_state_t      state;
        logic [CNT_W-1:0] cnt;
        logic [AW-1:0]   addr;
        logic            sleep;
        logic            recov;
        logic            sel;
        logic            rd;
        logic            wr;
        logic [DW-1:0]   dq;
        logic            oe;
    } ssm_st_t;

    ssm_st_t st_r;
    ssm_st_t st_nxt;
    logic    req;
    logic    active;
    logic    gate_open;

    ////////////////////////////////////////////////////////////////////////////
    // Command decode, before any sleep gating
    logic             cmd_sel;
    logic             cmd_rd;
    logic             cmd_wr;
    logic             cmd_load;
    logic             cmd_step;
    logic [AW-1:0]    addr_nxt;
    logic [CNT_W-1:0] entry_last;
    logic [CNT_W-1:0] recov_last;

    assign req = sync_bus.sleep_req;

    // Last count value of each timed phase
    assign entry_last = CNT_W'(ENTRY_CYC) - CNT_ONE;
    assign recov_last = CNT_W'(RECOVERY_CYC) - CNT_ONE;

    assign cmd_sel  = SELECT_I;
    assign cmd_rd   = SELECT_I & READ_I;
    assign cmd_wr   = SELECT_I & WRITE_I;
    assign cmd_load = SELECT_I & LOAD_I;

    // Dummy reads step the counter exactly like ordinary reads
    assign cmd_step = SELECT_I & ADVANCE_I & (READ_I | WRITE_I);

    // Load wins over advance; otherwise the counter holds
    always_comb begin
        addr_nxt = st_r.addr;
        if (cmd_load) begin
            addr_nxt = ADDR_I;
        end else if (cmd_step) begin
            addr_nxt = st_r.addr + AW'(ADDR_ONE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sleep sequencer and command gating
    always_comb begin
        st_nxt    = st_r;
        active    = 1'b0;
        gate_open = 1'b0;

        // Phase sequencing on the synchronised request
        case (st_r.state)
            SSM_RUN: begin
                active = 1'b1;
                if (req) begin
                    st_nxt.state = SSM_ENTER;
                    st_nxt.cnt   = CNT_ONE;
                end
            end
            SSM_ENTER: begin
                active = 1'b1;
                if (!req) begin
                    st_nxt.state = SSM_RUN;
                end else if (st_r.cnt >= entry_last) begin
                    st_nxt.state = SSM_SLEEP;
                end else begin
                    st_nxt.cnt = st_r.cnt + CNT_ONE;
                end
            end
            SSM_SLEEP: begin
                if (!req) begin
                    st_nxt.state = SSM_RECOVER;
                    st_nxt.cnt   = CNT_ZERO;
                end
            end
            SSM_RECOVER: begin
                if (req) begin
                    st_nxt.state = SSM_SLEEP;
                end else if (st_r.cnt >= recov_last) begin
                    st_nxt.state = SSM_RUN;
                end else begin
                    st_nxt.cnt = st_r.cnt + CNT_ONE;
                end
            end
            default: begin
                st_nxt.state = SSM_RUN;
            end
        endcase


        // The core stays open in run and recovery, but never on the
        // edge that lands in sleep, so no command leaks into sleep
        gate_open = (active || (st_r.state == SSM_RECOVER)) &&
                    (st_nxt.state != SSM_SLEEP);

        // Recovery admits deselect and reads; writes are dropped
        if (gate_open) begin
            st_nxt.sel  = cmd_sel;
            st_nxt.rd   = cmd_rd;
            st_nxt.wr   = active & cmd_wr;
            st_nxt.addr = addr_nxt;
            st_nxt.dq   = RDATA_I;

            // Dummy read: launched normally, drivers held off
            st_nxt.oe   = st_r.rd & ~OUT_GATE_I;
        end else begin
            st_nxt.sel = 1'b0;
            st_nxt.rd  = 1'b0;
            st_nxt.wr  = 1'b0;
            st_nxt.oe  = 1'b0;
        end

        // Status flags follow the next state so they leave a flop
        st_nxt.sleep = (st_nxt.state == SSM_SLEEP);
        st_nxt.recov = (st_nxt.state == SSM_RECOVER);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; reset wins, otherwise a low enable freezes everything
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            st_r       <= '0;
            st_r.state <= SSM_RUN;
        end else if (CE_I) begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, each straight from the state register
    assign SLEEP_O      = st_r.sleep;
    assign RECOVERING_O = st_r.recov;
    assign SELECT_O     = st_r.sel;
    assign READ_O       = st_r.rd;
    assign WRITE_O      = st_r.wr;
    assign BURST_ADDR_O = st_r.addr;
    assign DQ_O         = st_r.dq;
    assign DQ_OE_O      = st_r.oe;
endmodule : ssm_top

// File: tb/ssm_top_monitor.sv
// Checker for sleep entry, exit and command gating
`timescale 1ns/1ns
module ssm_top_monitor (
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire logic SLEEP_REQUEST_I,
    input wire logic SELECT_I,
    input wire logic READ_I,
    input wire logic WRITE_I,
    input wire logic SLEEP_O,
    input wire logic RECOVERING_O,
    input wire logic SELECT_O,
    input wire logic READ_O,
    input wire logic WRITE_O,
    input wire logic DQ_OE_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (SRST_I);
    property p_entry; $rose(SLEEP_REQUEST_I) && !SLEEP_O |-> !SLEEP_O[*3] ##[1:3] SLEEP_O; endproperty
    a_entry: assert property (p_entry) else $error("late entry");
    property p_quiet; SLEEP_O |-> !(SELECT_O || READ_O || WRITE_O || DQ_OE_O); endproperty
    a_quiet: assert property (p_quiet) else $error("active asleep");
    property p_hold; SLEEP_O && SLEEP_REQUEST_I |=> SLEEP_O; endproperty
    a_hold: assert property (p_hold) else $error("early wake");
    property p_exit; $fell(SLEEP_REQUEST_I) && SLEEP_O |-> SLEEP_O[*3] ##[1:2] RECOVERING_O; endproperty
    a_exit: assert property (p_exit) else $error("bad exit");
    property p_rec; $rose(RECOVERING_O) |-> RECOVERING_O[*2] ##1 !RECOVERING_O; endproperty
    a_rec: assert property (p_rec) else $error("recovery length");
    property p_nowr; RECOVERING_O && WRITE_I |=> !WRITE_O; endproperty
    a_nowr: assert property (p_nowr) else $error("write in recovery");
    property p_rd; RECOVERING_O && SELECT_I && READ_I |=> READ_O; endproperty
    a_rd: assert property (p_rd) else $error("read lost");
    property p_awake; (!SLEEP_O && !SLEEP_REQUEST_I)[*3] |=> !SLEEP_O; endproperty
    a_awake: assert property (p_awake) else $error("spurious sleep");
    c_sleep: cover property ($rose(SLEEP_O));
    c_wake: cover property ($fell(RECOVERING_O));
    c_drop: cover property (RECOVERING_O && WRITE_I);
endmodule : ssm_top_monitor
bind ssm_top ssm_top_monitor ssm_top_monitor_i (.*);

// File: tb/ssm_host_model.sv
// Host controller model driving the command pins
`timescale 1ns/1ns
module ssm_host_model (
    input  wire logic clk_i,
    input  wire logic sleep_i,
    input  wire logic rd_i,
    input  wire logic wr_i,
    input  wire logic busy_i,
    output logic      req_o,
    output logic      sel_o,
    output logic      rd_o,
    output logic      wr_o,
    output logic      adv_o
);
    logic req_r;
    always_ff @(posedge clk_i) req_r <= req_o;
    // Sleep is raised only with nothing in flight
    assign req_o = sleep_i && (req_r || !busy_i);
    assign sel_o = rd_i || wr_i;
    assign rd_o = rd_i;
    assign wr_o = wr_i;
    assign adv_o = rd_i;
endmodule : ssm_host_model

// File: tb/tb_ssm_top.sv
// Testbench for the sleep-mode control block
`timescale 1ns/1ns
module tb_ssm_top
    import ssm_pkg::*;
;
    localparam logic [DATA_W-1:0] RD_PAT = 18'h2a5c3;
    logic CLK_I, SRST_I, ce, slp, rd, wr, ld, gate, req, sel, rdp, wrp, adv;
    logic [DATA_W-1:0] DQ_O;
    logic SLEEP_O, RECOVERING_O, SELECT_O, READ_O, WRITE_O, DQ_OE_O;
    logic [ADDR_W-1:0] BURST_ADDR_O;
    int error_cnt = 0, compares = 0, cyc = 0;
    ssm_top ssm_top_i (.CLK_I(CLK_I), .SRST_I(SRST_I), .CE_I(ce), .SLEEP_REQUEST_I(req),
        .SELECT_I(sel), .READ_I(rdp), .WRITE_I(wrp), .LOAD_I(ld), .ADVANCE_I(adv),
        .ADDR_I(2'h2), .OUT_GATE_I(gate), .RDATA_I(RD_PAT), .SLEEP_O(SLEEP_O),
        .RECOVERING_O(RECOVERING_O), .SELECT_O(SELECT_O), .READ_O(READ_O),
        .WRITE_O(WRITE_O), .BURST_ADDR_O(BURST_ADDR_O), .DQ_O(DQ_O), .DQ_OE_O(DQ_OE_O));
    ssm_host_model ssm_host_model_i (.clk_i(CLK_I), .sleep_i(slp), .rd_i(rd), .wr_i(wr),
        .busy_i(READ_O || WRITE_O), .req_o(req), .sel_o(sel), .rd_o(rdp), .wr_o(wrp),
        .adv_o(adv));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic ticks(input int n);
        repeat (n) @(negedge CLK_I);
    endtask : ticks
    task automatic close_out;
        $display("error_cnt %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    task automatic t_dummy;
        rd = 1; ld = 1; ticks(1);
        chk({SELECT_O, READ_O}, 3);
        chk(DQ_O, RD_PAT);
        ld = 0; gate = 1; ticks(1);
        chk(DQ_OE_O, 0);
        rd = 0; gate = 0; ticks(3);
        chk(BURST_ADDR_O, 3);
    endtask : t_dummy
    task automatic t_sleep;
        slp = 1; ticks(8);
        chk(SLEEP_O, 1);
        rd = 1; ticks(2);
        // Outputs quiet, burst address 3 kept through sleep
        chk({READ_O, DQ_OE_O, BURST_ADDR_O}, 3);
        rd = 0; slp = 0;
        for (int i = 0; i < 10 && RECOVERING_O !== 1'b1; i++) ticks(1);
        chk(RECOVERING_O, 1);
        wr = 1; ticks(1);
        chk(WRITE_O, 0);
        wr = 0; rd = 1; ticks(1);
        chk(READ_O, 1);
        rd = 0; ticks(3);
        // Kept address 3 plus one read wraps to 0
        chk({SLEEP_O, RECOVERING_O, BURST_ADDR_O}, 0);
    endtask : t_sleep
    task automatic t_freeze;
        ce = 0; rd = 1; ld = 1; ticks(2);
        chk({READ_O, BURST_ADDR_O}, 0);
        ce = 1; ticks(1);
        chk({READ_O, BURST_ADDR_O}, 6);
        rd = 0; ld = 0; ticks(2);
    endtask : t_freeze
    initial begin
        CLK_I = 0;
        forever #5 CLK_I = ~CLK_I;
    end
    always @(posedge CLK_I) begin
        cyc <= cyc + 1;
        if (cyc > 500) begin
            error_cnt++;
            close_out();
        end
    end
    initial begin
        {slp, rd, wr, ld, gate} = 0;
        ce = 1;
        SRST_I = 1;
        ticks(4);
        SRST_I = 0;
        t_dummy();
        t_sleep();
        t_freeze();
        close_out();
    end
endmodule : tb_ssm_top
